//--- fpllc_ref_div.sv
// fpllc_pkg: shared constants of the fractional pll controller
// fpllc_ref_div: divider on the main crystal path feeding the reference mux
// assumes the crystal level is a synchronous input sampled on sys_clk
package fpllc_pkg;
	localparam int          INT_W        = 12;
	localparam int          FRAC_W       = 4;
	localparam int          FRAC_DEN     = 16;
	localparam int          DIV_W        = 11;
	localparam int          LOCK_TIME_SELECT_W      = 3;
	localparam int          LT_CNT_W     = 8;
	localparam int          FILT_W       = 2;
	localparam int          LT_STEP      = 8;
	localparam logic [1:0]  REF_XTAL32K  = 2'h0;
	localparam logic [1:0]  REF_XOSC_DIV = 2'h1;
	localparam logic [1:0]  REF_GENERIC  = 2'h2;
	localparam logic [1:0]  FILT_AUTO_INT  = 2'h0;
	localparam logic [1:0]  FILT_AUTO_FRAC = 2'h1;
	localparam int          FLAG_LOCK_FAIL = 0;
	localparam int          FLAG_TIMEOUT   = 1;
	localparam int          NUM_FLAGS      = 2;
	typedef enum logic [3:0] {
		FPLLC_OFF     = 4'h1,
		FPLLC_STARTUP = 4'h2,
		FPLLC_ACQUIRE = 4'h4,
		FPLLC_RUN     = 4'h8
	} fpllc_state_t;
endpackage : fpllc_pkg

`timescale 1ns/10ps
module fpllc_ref_div #(
	parameter int DIV_W = fpllc_pkg::DIV_W
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// crystal in, divided clock out
	input  wire logic             xosc_in,
	input  wire logic [DIV_W-1:0] div_value,
	output logic                  div_out
);
	logic             xosc_d_r;
	logic [DIV_W-1:0] cnt_r;
	logic             div_r;
	wire              xosc_rise = xosc_in & ~xosc_d_r;
	wire              cnt_end   = (cnt_r >= div_value);

	// toggle after div+1 rising edges gives f/(2*(div+1))
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			xosc_d_r <= 1'b0;
			cnt_r    <= '0;
			div_r    <= 1'b0;
		end else begin
			xosc_d_r <= xosc_in;
			if (xosc_rise) begin
				cnt_r <= cnt_end ? '0 : cnt_r + 1'b1;
				if (cnt_end) begin
					div_r <= ~div_r;
				end
			end
		end
	end

	assign div_out = div_r;
endmodule : fpllc_ref_div

//--- fpllc_ctrl.sv
// fpllc_ctrl: control logic around a fractional digital pll
// assumes the loop core, oscillators and clock sources are outside; their
// levels arrive as synchronous inputs sampled on sys_clk
// How it works
// - multiplier word to core is ratio_integer plus one plus ratio_fraction sixteenths
// - main crystal divided by two times divider plus one
// - output clock held low while loop disabled
// - integer mode when fraction zero, fractional mode otherwise
// - enable bit starts loop, clearing it stops loop
// - frequency stable only while enabled and lock set
// - nonzero lock time: lock validated by timer, first edge at zero count
// - zero lock time: lock follows core status, first edge at lock
// - wake fast opens output gate right after oscillator start-up
// - after first lock gate follows lock unless lock bypass set
// - ratio writes while enabled clear lock, lock returns once settled
// - lock fail flag set on lock falling edge in run state, write one clears
// - references: 32k crystal, divided main crystal, generic clock
// - filter automatic unless software override given
// - tdc bypass enable bypasses time to digital converter
// - lock timer counts edges of the 32 kHz lock timer clock
// - lock timeout flag set when programmed lock time elapses
// - irq when a flag and its enable are set; set and clear strobes
`timescale 1ns/10ps
module fpllc_ctrl #(
	parameter int INT_W   = fpllc_pkg::INT_W,
	parameter int DIV_W   = fpllc_pkg::DIV_W,
	parameter int LT_STEP = fpllc_pkg::LT_STEP
) (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// control a
	input  wire logic                          pll_enable,
	// ratio register
	input  wire logic [INT_W-1:0]              ratio_integer,
	input  wire logic [fpllc_pkg::FRAC_W-1:0]  ratio_fraction,
	input  wire logic                          ratio_write,
	// control b
	input  wire logic [1:0]                    ref_select,
	input  wire logic [DIV_W-1:0]              xosc_div,
	input  wire logic [fpllc_pkg::LOCK_TIME_SELECT_W-1:0] lock_time_select,
	input  wire logic                          wake_fast,
	input  wire logic                          lock_gate_bypass,
	input  wire logic                          filter_override,
	input  wire logic [fpllc_pkg::FILT_W-1:0]  filter_value,
	input  wire logic                          tdc_bypass_enable,
	// interrupt control, write-one strobes
	input  wire logic [1:0]                    irq_flags_clear,
	input  wire logic [1:0]                    irq_enable_set,
	input  wire logic [1:0]                    irq_enable_clear,
	// clock sources and core status
	input  wire logic                          crystal_32k,
	input  wire logic                          xosc_clock,
	input  wire logic                          generic_ref_clock,
	input  wire logic                          lock_timer_clock,
	input  wire logic                          oscillator_raw_clock,
	input  wire logic                          core_startup_done,
	input  wire logic                          core_locked,
	// to loop core
	output logic                               pll_ref_clock,
	output logic                               core_enable,
	output logic [INT_W+fpllc_pkg::FRAC_W-1:0] core_multiplier,
	output logic                               fractional_mode,
	output logic [fpllc_pkg::FILT_W-1:0]       filter_setting,
	output logic                               time_digital_conv_bypass,
	// output clock and status
	output logic                               pll_out_clock,
	output logic                               lock_status,
	output logic                               freq_stable,
	output logic [1:0]                         irq_flags,
	output logic [1:0]                         irq_enable,
	output logic                               irq
);
	fpllc_pkg::fpllc_state_t state_r, state_nxt;

	logic                      lock_r, lock_nxt;
	logic                      ltclk_d_r;
	logic [fpllc_pkg::LT_CNT_W-1:0] lt_cnt_r, lt_cnt_nxt;
	logic                      lt_run_r, lt_run_nxt;
	logic                      lt_done_r, lt_done_nxt;
	logic [1:0]                flags_r, flags_nxt;
	logic [1:0]                ien_r;
	logic                      irq_r;
	logic                      ref_r;
	logic                      out_r;
	logic                      acq_done_r;
	logic [INT_W+fpllc_pkg::FRAC_W-1:0] mult_r;
	logic                      xosc_div_clk;

	fpllc_ref_div #(
		.DIV_W    (DIV_W)
	) u_ref_div (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.xosc_in  (xosc_clock),
		.div_value(xosc_div),
		.div_out  (xosc_div_clk)
	);

	// decode
	wire timer_mode  = (lock_time_select != '0);
	wire lt_tick     = lock_timer_clock & ~ltclk_d_r;
	wire is_off      = (state_r == fpllc_pkg::FPLLC_OFF);
	wire is_run      = (state_r == fpllc_pkg::FPLLC_RUN);
	wire ratio_upd   = ratio_write & ~is_off;
	wire lt_start    = (is_off & pll_enable) | ratio_upd;
	wire lt_expire   = lt_run_r & lt_tick & (lt_cnt_r == '0);
	wire settled     = timer_mode ? lt_done_r : core_locked;
	wire lock_fall   = lock_r & ~lock_nxt & is_run;
	// wake fast holds the gate open only until the first lock has been seen
	wire gate_open   = is_run & (lock_gate_bypass | lock_r | (wake_fast & ~acq_done_r));
	wire [fpllc_pkg::LT_CNT_W-1:0] lt_load =
		fpllc_pkg::LT_CNT_W'(lock_time_select * LT_STEP - 1);

	// reserved select code falls back to the 32k crystal
	wire ref_mux = (ref_select == fpllc_pkg::REF_XOSC_DIV) ? xosc_div_clk :
	               (ref_select == fpllc_pkg::REF_GENERIC)  ? generic_ref_clock :
	               crystal_32k;

	// sequence from enable to first output edge
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			fpllc_pkg::FPLLC_OFF: begin
				if (pll_enable) state_nxt = fpllc_pkg::FPLLC_STARTUP;
			end
			fpllc_pkg::FPLLC_STARTUP: begin
				if (core_startup_done) begin
					state_nxt = wake_fast ? fpllc_pkg::FPLLC_RUN : fpllc_pkg::FPLLC_ACQUIRE;
				end
			end
			fpllc_pkg::FPLLC_ACQUIRE: begin
				if (timer_mode ? lt_done_r : core_locked) state_nxt = fpllc_pkg::FPLLC_RUN;
			end
			fpllc_pkg::FPLLC_RUN: ;
			default: state_nxt = fpllc_pkg::FPLLC_OFF;
		endcase
		if (!pll_enable) state_nxt = fpllc_pkg::FPLLC_OFF;
	end

	// lock timer, restarted at enable and on every ratio update
	always_comb begin
		lt_cnt_nxt  = lt_cnt_r;
		lt_run_nxt  = lt_run_r;
		lt_done_nxt = lt_done_r;
		if (!pll_enable || !timer_mode) begin
			lt_run_nxt  = 1'b0;
			lt_done_nxt = 1'b0;
		end else if (lt_start) begin
			lt_cnt_nxt  = lt_load;
			lt_run_nxt  = 1'b1;
			lt_done_nxt = 1'b0;
		end else if (lt_run_r && lt_tick) begin
			if (lt_expire) begin
				lt_run_nxt  = 1'b0;
				lt_done_nxt = 1'b1;
			end else begin
				lt_cnt_nxt = lt_cnt_r - 1'b1;
			end
		end
	end

	// a ratio update drops lock for at least one cycle
	assign lock_nxt = pll_enable & ~is_off & ~ratio_upd & settled;

	// set wins over a clear arriving in the same cycle
	always_comb begin
		flags_nxt = flags_r & ~irq_flags_clear;
		if (lock_fall) flags_nxt[fpllc_pkg::FLAG_LOCK_FAIL] = 1'b1;
		if (lt_expire) flags_nxt[fpllc_pkg::FLAG_TIMEOUT] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= fpllc_pkg::FPLLC_OFF;
			lock_r    <= 1'b0;
			ltclk_d_r <= 1'b0;
			lt_cnt_r  <= '0;
			lt_run_r  <= 1'b0;
			lt_done_r <= 1'b0;
			flags_r   <= '0;
			acq_done_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			lock_r    <= lock_nxt;
			ltclk_d_r <= lock_timer_clock;
			lt_cnt_r  <= lt_cnt_nxt;
			lt_run_r  <= lt_run_nxt;
			lt_done_r <= lt_done_nxt;
			flags_r   <= flags_nxt;
			acq_done_r <= ~is_off & (acq_done_r | lock_r);
		end
	end

	// enable set wins over clear when both strobe together
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ien_r <= '0;
			irq_r <= 1'b0;
		end else begin
			ien_r <= (ien_r & ~irq_enable_clear) | irq_enable_set;
			irq_r <= |(flags_nxt & ((ien_r & ~irq_enable_clear) | irq_enable_set));
		end
	end

	// clock paths; gated level is zero from the second cycle the loop is off
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_r  <= 1'b0;
			out_r  <= 1'b0;
			mult_r <= '0;
		end else begin
			ref_r  <= ref_mux;
			out_r  <= gate_open & oscillator_raw_clock;
			mult_r <= {ratio_integer + 1'b1, ratio_fraction};
		end
	end

	assign pll_ref_clock            = ref_r;
	assign pll_out_clock            = out_r;
	assign core_enable              = ~is_off;
	assign core_multiplier          = mult_r;
	assign fractional_mode          = (ratio_fraction != '0);
	assign filter_setting           = filter_override ? filter_value :
	                                  (fractional_mode ? fpllc_pkg::FILT_AUTO_FRAC
	                                                   : fpllc_pkg::FILT_AUTO_INT);
	assign time_digital_conv_bypass = tdc_bypass_enable;
	assign lock_status              = lock_r;
	assign freq_stable              = pll_enable & lock_r;
	assign irq_flags                = flags_r;
	assign irq_enable               = ien_r;
	assign irq                      = irq_r;
endmodule : fpllc_ctrl

//--- fpllc_ctrl_sva.sv
// fpllc_ctrl_sva: port checks for the pll controller
// assumes default widths and a bind onto fpllc_ctrl
`timescale 1ns/10ps
module fpllc_ctrl_sva (
	// clock and reset
	input wire logic		sys_clk,
	input wire logic		rst_n,
	// controls
	input wire logic		pll_enable,
	input wire logic [11:0]	ratio_integer,
	input wire logic [3:0]	ratio_fraction,
	input wire logic		ratio_write,
	input wire logic		wake_fast,
	input wire logic		lock_gate_bypass,
	input wire logic		filter_override,
	// outputs
	input wire logic		core_enable,
	input wire logic [15:0]	core_multiplier,
	input wire logic		fractional_mode,
	input wire logic [1:0]	filter_setting,
	input wire logic		pll_out_clock,
	input wire logic		lock_status,
	input wire logic		freq_stable,
	input wire logic [1:0]	irq_flags,
	input wire logic [1:0]	irq_enable,
	input wire logic		irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_rewrite;
		ratio_write && core_enable;
	endsequence
	sequence s_gate_shut;
		!lock_gate_bypass && !lock_status && !wake_fast;
	endsequence
	a_mult_word: assert property ($past(rst_n) |->
		core_multiplier == {$past(ratio_integer) + 12'h001, $past(ratio_fraction)}) else $error("bad multiplier");
	a_frac_mode: assert property (fractional_mode == (ratio_fraction != 4'h0) &&
		(filter_override || filter_setting == {1'b0, fractional_mode})) else $error("bad mode or filter");
	a_off_quiet: assert property (!core_enable |=> !pll_out_clock)
		else $error("output clock while off");
	a_enable_follow: assert property ($past(rst_n) |-> core_enable == $past(pll_enable))
		else $error("loop enable not followed");
	a_stable_def: assert property (freq_stable == (pll_enable && lock_status))
		else $error("bad stable flag");
	a_gate_shut: assert property (s_gate_shut |=> !pll_out_clock)
		else $error("gate open without lock");
	a_ratio_drop: assert property (s_rewrite |=> !lock_status)
		else $error("lock kept over ratio write");
	a_irq_level: assert property (irq == |(irq_flags & irq_enable))
		else $error("bad irq level");
endmodule : fpllc_ctrl_sva
bind fpllc_ctrl fpllc_ctrl_sva chk (.*);

//--- fpllc_core_model.sv
// fpllc_core_model: behavioural loop core and oscillators
// assumes enable and multiplier come from the controller
`timescale 1ns/10ps
module fpllc_core_model (
	// clock and reset
	input wire logic		sys_clk,
	input wire logic		rst_n,
	// from controller and bench
	input wire logic		core_enable,
	input wire logic [15:0]	core_multiplier,
	input wire logic [7:0]	lock_cyc,
	// to controller
	output logic			raw_clk,
	output logic			startup_done,
	output logic			locked,
	output logic			timer_clk
);
	logic [7:0]		cnt_r;
	logic [15:0]	mult_r;
	wire			same_w = mult_r == core_multiplier;
	// a slow lock_cyc lets the timer win the race
	assign startup_done = core_enable && cnt_r >= 8'h04;
	assign locked = startup_done && same_w && cnt_r >= lock_cyc;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			mult_r <= 16'h0000;
			raw_clk <= 1'b0;
			timer_clk <= 1'b0;
		end else begin
			// lock timer clock runs free, scaled to sys_clk/2
			timer_clk <= ~timer_clk;
			raw_clk <= core_enable && !raw_clk;
			mult_r <= core_multiplier;
			if (!core_enable || !same_w)
				cnt_r <= 8'h00;
			else if (cnt_r != 8'hFF)
				cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule : fpllc_core_model

//--- fractional_pll_controller_tb_top.sv
// fractional_pll_controller_tb_top: scenario bench
// assumes the core model stands in for the loop core
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module fractional_pll_controller_tb_top;
	logic sys_clk = 1'b0, rst_n = 1'b0, en = 1'b0, wr = 1'b0, wf = 1'b0, lb = 1'b0, fo = 1'b0, tb = 1'b0;
	logic x32 = 1'b0, gen = 1'b0, ce, fm, time_digital_conv, outc, lock, stab, irq, refc, raw, sdone, clk_ok, tclk;
	logic [11:0] ri = 12'h5DB;
	logic [3:0] rf = 4'h3;
	logic [2:0] lt = 3'h0;
	logic [1:0] rs = 2'h0, fclr = 2'h0, eset = 2'h0, eclr = 2'h0, flg, ien, fset;
	logic [10:0] xdiv = 11'h001;
	logic [7:0] lcyc = 8'h0A;
	logic [15:0] mult;
	int compares = 0, miscompares = 0, i;
	fpllc_ctrl #(.LT_STEP(1)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .pll_enable(en), .ratio_integer(ri),
		.ratio_fraction(rf), .ratio_write(wr), .ref_select(rs), .xosc_div(xdiv), .lock_time_select(lt),
		.wake_fast(wf), .lock_gate_bypass(lb), .filter_override(fo), .filter_value(2'h3), .tdc_bypass_enable(tb),
		.irq_flags_clear(fclr), .irq_enable_set(eset), .irq_enable_clear(eclr), .crystal_32k(x32), .xosc_clock(tclk),
		.generic_ref_clock(gen), .lock_timer_clock(tclk), .oscillator_raw_clock(raw), .core_startup_done(sdone),
		.core_locked(clk_ok), .pll_ref_clock(refc), .core_enable(ce), .core_multiplier(mult), .fractional_mode(fm),
		.filter_setting(fset), .time_digital_conv_bypass(time_digital_conv), .pll_out_clock(outc), .lock_status(lock),
		.freq_stable(stab), .irq_flags(flg), .irq_enable(ien), .irq(irq));
	fpllc_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .core_enable(ce), .core_multiplier(mult),
		.lock_cyc(lcyc), .raw_clk(raw), .startup_done(sdone), .locked(clk_ok), .timer_clk(tclk));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic wait_lock(input int lim);
		for (i = 0; i < lim && lock !== 1'b1; i++) @(posedge sys_clk) #1;
	endtask : wait_lock
	task automatic out_seen(input int n, output logic s);
		s = 1'b0;
		repeat (n) @(posedge sys_clk) #1 s |= outc;
	endtask : out_seen
	task s_core_lock;
		logic s;
		@(posedge sys_clk) en <= 1'b1;
		tb <= 1'b1;
		out_seen(8, s);
		`CHK("out before lock", 1'b0, s)
		wait_lock(40);
		`CHK("core lock", 1'b1, lock)
		`CHK("stable", 1'b1, stab)
		`CHK("multiplier", {ri + 12'h001, rf}, mult)
		`CHK("frac mode", 1'b1, fm)
		`CHK("auto filter", 2'h1, fset)
		`CHK("tdc bypass", 1'b1, time_digital_conv)
		out_seen(6, s);
		`CHK("out running", 1'b1, s)
		@(posedge sys_clk) fo <= 1'b1;
		@(posedge sys_clk) #1 `CHK("filter override", 2'h3, fset)
		@(posedge sys_clk) fo <= 1'b0;
		$display("test core_lock done");
	endtask : s_core_lock
	task s_ratio_update;
		@(posedge sys_clk) eset <= 2'h1;
		rf <= 4'h0;
		wr <= 1'b1;
		@(posedge sys_clk) eset <= 2'h0;
		wr <= 1'b0;
		#1 `CHK("lock dropped", 1'b0, lock)
		@(posedge sys_clk) #1 `CHK("irq enabled", 2'h1, ien)
		@(posedge sys_clk) #1 `CHK("fail flag", 2'h1, flg)
		`CHK("irq on", 1'b1, irq)
		wait_lock(40);
		`CHK("relock", 1'b1, lock)
		`CHK("new word", {ri + 12'h001, 4'h0}, mult)
		`CHK("int mode", 1'b0, fm)
		`CHK("auto int", 2'h0, fset)
		@(posedge sys_clk) fclr <= 2'h1;
		@(posedge sys_clk) fclr <= 2'h0;
		#1 `CHK("flag cleared", 2'h0, flg)
		`CHK("irq off", 1'b0, irq)
		@(posedge sys_clk) eclr <= 2'h1;
		@(posedge sys_clk) eclr <= 2'h0;
		#1 `CHK("irq disabled", 2'h0, ien)
		$display("test ratio_update done");
	endtask : s_ratio_update
	task s_wake_fast;
		logic s;
		@(posedge sys_clk) en <= 1'b0;
		wf <= 1'b1;
		lcyc <= 8'hC8;
		@(posedge sys_clk) en <= 1'b1;
		out_seen(14, s);
		`CHK("wake out", 1'b1, s)
		`CHK("still unlocked", 1'b0, lock)
		@(posedge sys_clk) wf <= 1'b0;
		out_seen(6, s);
		`CHK("gated off", 1'b0, s)
		@(posedge sys_clk) lb <= 1'b1;
		out_seen(6, s);
		`CHK("bypass out", 1'b1, s)
		@(posedge sys_clk) lb <= 1'b0;
		$display("test wake_fast done");
	endtask : s_wake_fast
	task s_timer_lock;
		logic s;
		@(posedge sys_clk) en <= 1'b0;
		lt <= 3'h2;
		@(posedge sys_clk) en <= 1'b1;
		wait_lock(40);
		`CHK("timer lock", 1'b1, lock)
		`CHK("core slow", 1'b0, clk_ok)
		out_seen(4, s);
		`CHK("timer out", 1'b1, s)
		`CHK("timeout flag", 1'b1, flg[1])
		@(posedge sys_clk) fclr <= 2'h3;
		@(posedge sys_clk) fclr <= 2'h0;
		$display("test timer_lock done");
	endtask : s_timer_lock
	task s_ref_switch;
		logic p;
		int   n;
		@(posedge sys_clk) en <= 1'b0;
		@(posedge sys_clk) #1 `CHK("core off", 1'b0, ce)
		// main crystal path: count reference rises over 32 cycles
		@(posedge sys_clk) rs <= 2'h1;
		cyc(2);
		#1 p = refc;
		n = 0;
		repeat (32) begin
			@(posedge sys_clk) #1 n += (refc & ~p);
			p = refc;
		end
		`CHK("divided ref", 32 / (4 * (xdiv + 1)), n)
		@(posedge sys_clk) rs <= 2'h2;
		gen <= 1'b1;
		#1 `CHK("out held", 1'b0, outc)
		cyc(2);
		#1 `CHK("generic ref", 1'b1, refc)
		@(posedge sys_clk) rs <= 2'h0;
		gen <= 1'b0;
		x32 <= 1'b1;
		cyc(2);
		#1 `CHK("crystal ref", 1'b1, refc)
		@(posedge sys_clk) en <= 1'b1;
		@(posedge sys_clk) #1 `CHK("core on", 1'b1, ce)
		$display("test ref_switch done");
	endtask : s_ref_switch
	task print_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		cyc(10);
		rst_n <= 1'b1;
		cyc(2);
		s_core_lock();
		s_ratio_update();
		s_wake_fast();
		s_timer_lock();
		s_ref_switch();
		print_verdict();
	end
	initial begin
		#50000;
		miscompares++;
		print_verdict();
	end
endmodule : fractional_pll_controller_tb_top
